//--- hdl/csts_defs.svh
// Register offsets, field positions and reset values of the capture source selector.
`ifndef CSTS_DEFS_SVH
`define CSTS_DEFS_SVH

`define CSTS_OFF_CTRL2 8'h00
`define CSTS_OFF_IRQ_STAT 8'h04
`define CSTS_OFF_IRQ_MASK 8'h08
`define CSTS_OFF_STATE 8'h0C

`define CSTS_SEL_LSB 0
`define CSTS_SEL_MSB 4
`define CSTS_TRIGSTAT_BIT 6
`define CSTS_TRIGMODE_BIT 7
`define CSTS_CASCADE_BIT 8

`define CSTS_IRQ_EVENT_BIT 0
`define CSTS_IRQ_TRIGSET_BIT 1
`define CSTS_IRQ_CFGFAULT_BIT 2

`define CSTS_CTRL2_RESET 16'h000D
`define CSTS_IRQ_RESET 3'h0

`endif

//--- hdl/csts_pkg.sv
// Types shared by the capture source selector files.
package csts_pkg;

  typedef enum logic [4:0] {
    SEL_NONE_LO = 5'h00,
    SEL_COMPARE1 = 5'h01,
    SEL_COMPARE2 = 5'h02,
    SEL_COMPARE3 = 5'h03,
    SEL_COMPARE4 = 5'h04,
    SEL_TRIGGEN = 5'h0A,
    SEL_TMR1 = 5'h0B,
    SEL_TMR2 = 5'h0C,
    SEL_TMR3 = 5'h0D,
    SEL_TMR4 = 5'h0E,
    SEL_TMR5 = 5'h0F,
    SEL_CAP1 = 5'h10,
    SEL_CAP2 = 5'h11,
    SEL_CAP3 = 5'h12,
    SEL_CAP4 = 5'h13,
    SEL_COMPARATOR1 = 5'h18,
    SEL_COMPARATOR2 = 5'h19,
    SEL_COMPARATOR3 = 5'h1A,
    SEL_CONVERTER = 5'h1B,
    SEL_CHARGE_TIME = 5'h1C,
    SEL_NONE_HI = 5'h1F
  } csts_sel_t;

  typedef struct packed {
    logic [4:0] timerEv;
    logic [3:0] captureEv;
    logic [3:0] compareEv;
    logic [2:0] comparatorEv;
    logic converterEv;
    logic chargeTimeEv;
    logic [3:0] trigGenOut;
  } csts_src_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wrData;
    logic wrStb;
    logic rdStb;
  } csts_bus_t;

  // Codes with no source behind them: the two explicit none codes.
  function automatic logic csts_is_none(input logic [4:0] code);
    csts_is_none = (code == SEL_NONE_LO) || (code == SEL_NONE_HI);
  endfunction

  // Codes that are neither a source nor an explicit none.
  function automatic logic csts_is_reserved(input logic [4:0] code);
    csts_is_reserved = ((code >= 5'h05) && (code <= 5'h09)) ||
                       ((code >= 5'h14) && (code <= 5'h17)) ||
                       (code == 5'h1D) || (code == 5'h1E);
  endfunction

endpackage

//--- hdl/csts_sync_mux.sv
// Source multiplexer: picks one on-chip event by the select code.
`timescale 1ns/1ps
`default_nettype none

module csts_sync_mux (
  input wire csts_pkg::csts_src_t src,
  input wire logic ownTrigGen,
  input wire logic [4:0] sel,
  output logic selEvent,
  output logic selNone
);

  // ==========================================================
  // Selection
  function automatic logic pick(input csts_pkg::csts_src_t v, input logic tg,
                                input logic [4:0] s);
    logic r;
    r = 1'b0;
    case (s)
      csts_pkg::SEL_COMPARE1: r = v.compareEv[0];
      csts_pkg::SEL_COMPARE2: r = v.compareEv[1];
      csts_pkg::SEL_COMPARE3: r = v.compareEv[2];
      csts_pkg::SEL_COMPARE4: r = v.compareEv[3];
      csts_pkg::SEL_TRIGGEN: r = tg;
      csts_pkg::SEL_TMR1: r = v.timerEv[0];
      csts_pkg::SEL_TMR2: r = v.timerEv[1];
      csts_pkg::SEL_TMR3: r = v.timerEv[2];
      csts_pkg::SEL_TMR4: r = v.timerEv[3];
      csts_pkg::SEL_TMR5: r = v.timerEv[4];
      csts_pkg::SEL_CAP1: r = v.captureEv[0];
      csts_pkg::SEL_CAP2: r = v.captureEv[1];
      csts_pkg::SEL_CAP3: r = v.captureEv[2];
      csts_pkg::SEL_CAP4: r = v.captureEv[3];
      csts_pkg::SEL_COMPARATOR1: r = v.comparatorEv[0];
      csts_pkg::SEL_COMPARATOR2: r = v.comparatorEv[1];
      csts_pkg::SEL_COMPARATOR3: r = v.comparatorEv[2];
      csts_pkg::SEL_CONVERTER: r = v.converterEv;
      csts_pkg::SEL_CHARGE_TIME: r = v.chargeTimeEv;
      default: r = 1'b0;
    endcase
    pick = r;
  endfunction

  wire logic isNone;
  wire logic isReserved;

  assign isNone = csts_pkg::csts_is_none(sel);
  assign isReserved = csts_pkg::csts_is_reserved(sel);
  assign selNone = isNone | isReserved;
  assign selEvent = pick(src, ownTrigGen, sel);

endmodule // csts_sync_mux

`default_nettype wire

//--- hdl/csts_top.sv
// Capture channel synchronization and trigger source selector with its registers.
`timescale 1ns/1ps
`default_nettype none
`include "csts_defs.svh"

module csts_top #(
  parameter int unsigned CHANNEL = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] busAddr,
  input wire logic [15:0] busWrData,
  input wire logic busWrStb,
  input wire logic busRdStb,
  output logic [15:0] busRdData,
  input wire csts_pkg::csts_src_t src,
  input wire logic partnerCascadeEn,
  output logic syncTrigEvent,
  output logic trigMode,
  output logic trigStatus,
  output logic cascadeEnable,
  output logic cascadeActive,
  output logic irq
);

  // ==========================================================
  // Bus request bundle and decode
  csts_pkg::csts_bus_t bus;

  assign bus.addr = busAddr;
  assign bus.wrData = busWrData;
  assign bus.wrStb = busWrStb;
  assign bus.rdStb = busRdStb;

  wire logic hitCtrl;
  wire logic hitStat;
  wire logic hitMask;
  wire logic hitState;
  wire logic wrCtrl;
  wire logic wrStat;
  wire logic wrMask;

  assign hitCtrl = (bus.addr == `CSTS_OFF_CTRL2);
  assign hitStat = (bus.addr == `CSTS_OFF_IRQ_STAT);
  assign hitMask = (bus.addr == `CSTS_OFF_IRQ_MASK);
  assign hitState = (bus.addr == `CSTS_OFF_STATE);
  assign wrCtrl = bus.wrStb & hitCtrl;
  assign wrStat = bus.wrStb & hitStat;
  assign wrMask = bus.wrStb & hitMask;

  // ==========================================================
  // Control register fields
  localparam logic [15:0] CTRL_RST = `CSTS_CTRL2_RESET;

  logic [4:0] selR;
  logic [4:0] selNxt;
  logic modeR;
  logic modeNxt;
  logic trigR;
  logic trigNxt;
  logic cascR;
  logic cascNxt;

  assign selNxt = wrCtrl ? bus.wrData[`CSTS_SEL_MSB:`CSTS_SEL_LSB] : selR;
  assign modeNxt = wrCtrl ? bus.wrData[`CSTS_TRIGMODE_BIT] : modeR;
  assign cascNxt = wrCtrl ? bus.wrData[`CSTS_CASCADE_BIT] : cascR;

  // ==========================================================
  // Source selection
  wire logic ownTrigGen;
  wire logic muxEvent;
  wire logic muxNone;
  wire logic selfSelect;
  wire logic srcEvent;

  // Each channel owns exactly one trigger generator output.
  assign ownTrigGen = src.trigGenOut[CHANNEL - 1];

  csts_sync_mux u_mux (
    .src(src),
    .ownTrigGen(ownTrigGen),
    .sel(selR),
    .selEvent(muxEvent),
    .selNone(muxNone)
  );

  // A channel fed by its own capture event would retrigger itself forever,
  // so that code is blocked here as well as flagged.
  assign selfSelect = (selR == 5'(csts_pkg::SEL_CAP1 + (CHANNEL - 1)));
  assign srcEvent = muxEvent & ~muxNone & ~selfSelect;

  // ==========================================================
  // Trigger status: the event wins over a software clear.
  assign trigNxt = srcEvent | (wrCtrl ? bus.wrData[`CSTS_TRIGSTAT_BIT] : trigR);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      selR <= CTRL_RST[`CSTS_SEL_MSB:`CSTS_SEL_LSB];
      modeR <= CTRL_RST[`CSTS_TRIGMODE_BIT];
      trigR <= CTRL_RST[`CSTS_TRIGSTAT_BIT];
      cascR <= CTRL_RST[`CSTS_CASCADE_BIT];
    end else begin
      selR <= selNxt;
      modeR <= modeNxt;
      trigR <= trigNxt;
      cascR <= cascNxt;
    end
  end

  // ==========================================================
  // Event output
  logic eventR;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eventR <= 1'b0;
    end else begin
      eventR <= srcEvent;
    end
  end

  assign syncTrigEvent = eventR;
  assign trigMode = modeR;
  assign trigStatus = trigR;
  assign cascadeEnable = cascR;
  // The pair runs wide only when both halves agree; one half alone stays 16-bit.
  assign cascadeActive = cascR & partnerCascadeEn;

  // ==========================================================
  // Interrupt status and mask
  wire logic cfgFault;
  wire logic [2:0] irqSet;
  logic [2:0] irqStatR;
  logic [2:0] irqStatNxt;
  logic [2:0] irqMaskR;
  logic [2:0] irqMaskNxt;

  // Reserved and self codes are flagged so software sees a dead configuration.
  assign cfgFault = wrCtrl &
    (csts_pkg::csts_is_reserved(bus.wrData[`CSTS_SEL_MSB:`CSTS_SEL_LSB]) |
     (bus.wrData[`CSTS_SEL_MSB:`CSTS_SEL_LSB] ==
      5'(csts_pkg::SEL_CAP1 + (CHANNEL - 1))));
  assign irqSet = {cfgFault, srcEvent & ~trigR, srcEvent};
  assign irqStatNxt = irqSet | (irqStatR & ~(wrStat ? bus.wrData[2:0] : 3'h0));
  assign irqMaskNxt = wrMask ? bus.wrData[2:0] : irqMaskR;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqStatR <= `CSTS_IRQ_RESET;
      irqMaskR <= `CSTS_IRQ_RESET;
    end else begin
      irqStatR <= irqStatNxt;
      irqMaskR <= irqMaskNxt;
    end
  end

  assign irq = |(irqStatR & irqMaskR);

  // ==========================================================
  // Read path: data stand one cycle after the strobe, zero otherwise.
  wire logic [15:0] ctrlView;
  wire logic [15:0] stateView;
  wire logic [15:0] rdMux;
  logic [15:0] rdDataR;

  assign ctrlView = {7'h00, cascR, modeR, trigR, 1'b0, selR};
  assign stateView = {13'h0000, muxNone, partnerCascadeEn, cascadeActive};
  assign rdMux = hitCtrl ? ctrlView :
                 hitStat ? {13'h0000, irqStatR} :
                 hitMask ? {13'h0000, irqMaskR} :
                 hitState ? stateView : 16'h0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdDataR <= 16'h0000;
    end else begin
      rdDataR <= bus.rdStb ? rdMux : 16'h0000;
    end
  end

  assign busRdData = rdDataR;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  wire logic [2:0] tmrIdx;
  wire logic [1:0] capIdx;
  wire logic [1:0] cmpIdx;
  wire logic [1:0] anaIdx;
  wire logic inTimer;
  wire logic inCapture;
  wire logic inCompare;
  wire logic inComparator;

  assign tmrIdx = 3'(selR - csts_pkg::SEL_TMR1);
  assign capIdx = 2'(selR - csts_pkg::SEL_CAP1);
  assign cmpIdx = 2'(selR - csts_pkg::SEL_COMPARE1);
  assign anaIdx = 2'(selR - csts_pkg::SEL_COMPARATOR1);
  assign inTimer = (selR >= csts_pkg::SEL_TMR1) && (selR <= csts_pkg::SEL_TMR5);
  assign inCapture = (selR >= csts_pkg::SEL_CAP1) && (selR <= csts_pkg::SEL_CAP4) &&
                     !selfSelect;
  assign inCompare = (selR >= csts_pkg::SEL_COMPARE1) && (selR <= csts_pkg::SEL_COMPARE4);
  assign inComparator = (selR >= csts_pkg::SEL_COMPARATOR1) &&
                        (selR <= csts_pkg::SEL_COMPARATOR3);

  sequence s_status_set;
    srcEvent ##1 trigStatus;
  endsequence

  sequence s_status_clear;
    wrCtrl && !bus.wrData[`CSTS_TRIGSTAT_BIT] && !srcEvent ##1 !trigStatus;
  endsequence

  sequence s_status_sw_set;
    wrCtrl && bus.wrData[`CSTS_TRIGSTAT_BIT] ##1 trigStatus;
  endsequence

  a_none_no_event: assert property (
    csts_pkg::csts_is_none(selR) |=> !syncTrigEvent)
    else $error("event passed with no source selected");

  a_reset_default: assert property (
    $fell(sys_rst) |-> selR == csts_pkg::SEL_TMR3 && !syncTrigEvent)
    else $error("select did not reset to timer three");

  a_timer_route: assert property (
    inTimer |=> syncTrigEvent == $past(src.timerEv[tmrIdx]))
    else $error("timer event not routed");

  a_capture_route: assert property (
    inCapture |=> syncTrigEvent == $past(src.captureEv[capIdx]))
    else $error("capture channel event not routed");

  a_compare_route: assert property (
    inCompare |=> syncTrigEvent == $past(src.compareEv[cmpIdx]))
    else $error("compare channel event not routed");

  a_analog_route: assert property (
    inComparator |=> syncTrigEvent == $past(src.comparatorEv[anaIdx]))
    else $error("comparator event not routed");

  a_conv_route: assert property (
    selR == csts_pkg::SEL_CONVERTER |=> syncTrigEvent == $past(src.converterEv))
    else $error("converter event not routed");

  a_charge_route: assert property (
    selR == csts_pkg::SEL_CHARGE_TIME |=> syncTrigEvent == $past(src.chargeTimeEv))
    else $error("charge-time event not routed");

  a_triggen_route: assert property (
    selR == csts_pkg::SEL_TRIGGEN |=>
      syncTrigEvent == $past(src.trigGenOut[CHANNEL - 1]))
    else $error("own trigger generator output not routed");

  a_self_blocked: assert property (
    selfSelect |=> !syncTrigEvent)
    else $error("channel retriggered by itself");

  a_trig_set: assert property (
    srcEvent |-> s_status_set)
    else $error("trigger status missed an event");

  a_trig_clear: assert property (
    wrCtrl && !bus.wrData[`CSTS_TRIGSTAT_BIT] && !srcEvent |-> s_status_clear)
    else $error("software clear of trigger status failed");

  a_trig_hold: assert property (
    !srcEvent && !wrCtrl |=> trigStatus == $past(trigStatus))
    else $error("trigger status changed without cause");

  a_cascade_pair: assert property (
    cascadeActive |-> cascadeEnable && partnerCascadeEn)
    else $error("cascade active without both enables");

  a_reserved_quiet: assert property (
    csts_pkg::csts_is_reserved(selR) |=> !syncTrigEvent[*1] ##0 !$rose(trigStatus))
    else $error("reserved code let an event through");

  a_irq_sticky: assert property (
    irqStatR[`CSTS_IRQ_EVENT_BIT] && !wrStat |=> irqStatR[`CSTS_IRQ_EVENT_BIT])
    else $error("sticky event flag dropped");

  a_read_late: assert property (
    bus.rdStb && hitCtrl |=> busRdData == $past(ctrlView))
    else $error("control read data wrong");

  a_trig_sw_set: assert property (
    wrCtrl && bus.wrData[`CSTS_TRIGSTAT_BIT] |-> s_status_sw_set)
    else $error("software set of trigger status failed");

  a_read_idle: assert property (
    !bus.rdStb |=> busRdData == 16'h0000)
    else $error("read data stood without a read strobe");

  a_read_unmapped: assert property (
    bus.rdStb && !(hitCtrl || hitStat || hitMask || hitState) |=> busRdData == 16'h0000)
    else $error("unmapped read returned data");

  // Set wins over a same-cycle clear, so a late event is never lost to software.
  a_irq_set_wins: assert property (
    srcEvent |=> irqStatR[`CSTS_IRQ_EVENT_BIT])
    else $error("event flag not set by a routed event");

  a_irq_clear: assert property (
    wrStat && bus.wrData[`CSTS_IRQ_EVENT_BIT] && !srcEvent |=>
      !irqStatR[`CSTS_IRQ_EVENT_BIT])
    else $error("event flag not cleared by a one");

  a_cfg_reserved: assert property (
    wrCtrl && csts_pkg::csts_is_reserved(bus.wrData[`CSTS_SEL_MSB:`CSTS_SEL_LSB]) |=>
      irqStatR[`CSTS_IRQ_CFGFAULT_BIT])
    else $error("reserved select code not flagged");

  a_sel_written: assert property (
    wrCtrl |=> selR == $past(bus.wrData[`CSTS_SEL_MSB:`CSTS_SEL_LSB]))
    else $error("select field write lost");

  a_none_status: assert property (
    csts_pkg::csts_is_none(selR) && !wrCtrl |=> !$rose(trigStatus))
    else $error("trigger status set with no source selected");

  a_cascade_both: assert property (
    cascadeEnable && partnerCascadeEn |-> cascadeActive)
    else $error("cascade inactive with both enables set");

  a_mask_written: assert property (
    wrMask |=> irqMaskR == $past(bus.wrData[2:0]))
    else $error("interrupt mask write lost");

endmodule // csts_top

`default_nettype wire

//--- verification/csts_src_model.sv
// Event source model for the timers, channels, comparators and converters around the selector.
`timescale 1ns/1ps
`default_nettype none

module csts_src_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic fireStb,
  input wire logic [21:0] fireMask,
  output var csts_pkg::csts_src_t src
);
  // ==========================================================================
  // Event pulses
  // Sources rest low between events, so any stray high seen downstream is a routing fault.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src <= '0;
    end else begin
      src <= fireStb ? csts_pkg::csts_src_t'(fireMask) : '0;
    end
  end
endmodule // csts_src_model
`default_nettype wire

//--- verification/tb_capture_sync_trigger_select.sv
// Self-checking testbench of the capture source selector.
`timescale 1ns/1ps
`default_nettype none
`include "csts_defs.svh"

module tb_capture_sync_trigger_select;
  localparam int CH = 3;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] busAddr = 8'h00;
  logic [15:0] busWrData = 16'h0000;
  logic busWrStb = 1'b0;
  logic busRdStb = 1'b0;
  logic [15:0] busRdData;
  csts_pkg::csts_src_t src;
  logic partnerCascadeEn = 1'b0;
  logic syncTrigEvent;
  logic trigMode;
  logic trigStatus;
  logic cascadeEnable;
  logic cascadeActive;
  logic irq;
  logic fireStb = 1'b0;
  logic [21:0] fireMask = 22'h000000;
  logic [15:0] rdVal;
  logic [15:0] cw;
  logic [15:0] n;
  int idx;
  int fail_count = 0;
  int num_checks = 0;

  csts_top #(.CHANNEL(CH)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .busAddr(busAddr), .busWrData(busWrData),
    .busWrStb(busWrStb), .busRdStb(busRdStb), .busRdData(busRdData), .src(src),
    .partnerCascadeEn(partnerCascadeEn), .syncTrigEvent(syncTrigEvent),
    .trigMode(trigMode), .trigStatus(trigStatus), .cascadeEnable(cascadeEnable),
    .cascadeActive(cascadeActive), .irq(irq)
  );

  csts_src_model i_src (
    .clk(clk), .sys_rst(sys_rst), .fireStb(fireStb), .fireMask(fireMask), .src(src)
  );

  initial begin
    forever #10 clk = ~clk;
  end

  // ==========================================================================
  // Bus and compare tasks
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    busAddr <= a;
    busWrData <= d;
    busWrStb <= 1'b1;
    @(posedge clk);
    busWrStb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    busAddr <= a;
    busRdStb <= 1'b1;
    @(posedge clk);
    busRdStb <= 1'b0;
    #1;
    d = busRdData;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Counts the routed pulses over a window wide enough to hold the one-cycle latency.
  task automatic fire(input logic [21:0] m, output logic [15:0] cnt);
    cnt = 16'h0000;
    @(posedge clk);
    fireMask <= m;
    fireStb <= 1'b1;
    @(posedge clk);
    fireStb <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (syncTrigEvent !== 1'b0) cnt = cnt + 16'h0001;
    end
  endtask

  // Bit position in the source vector that a code must route, or -1 for none.
  function automatic int srcIdx(input int c);
    if (c >= 1 && c <= 4) return 8 + c;
    if (c == 10) return CH - 1;
    if (c >= 11 && c <= 15) return 6 + c;
    if (c >= 16 && c <= 19) return (c - 16 == CH - 1) ? -1 : c - 3;
    if (c >= 24 && c <= 26) return c - 18;
    if (c == 27) return 5;
    if (c == 28) return 4;
    return -1;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`CSTS_OFF_CTRL2, rdVal);
    chk(rdVal, `CSTS_CTRL2_RESET);
    @(posedge clk);
    #1;
    chk(busRdData, 16'h0000);
    fire(22'h1 << 19, n);
    chk(n, 16'h0001);
    $display("test reset done");
    // Every code but the own capture code: all other sources must stay out, then the routed one must pass once.
    for (int c = 0; c < 32; c++) begin
      if (c == 16 + CH - 1) continue;
      idx = srcIdx(c);
      cw = 16'(c) | (((c >= 24) && (c <= 27)) ? 16'h0080 : 16'h0000);
      wr(`CSTS_OFF_CTRL2, cw);
      fire((idx < 0) ? 22'h3FFFFF : (22'h3FFFFF ^ (22'h1 << idx)), n);
      chk(n, 16'h0000);
      if (idx >= 0) begin
        fire(22'h1 << idx, n);
        chk(n, 16'h0001);
        rd(`CSTS_OFF_CTRL2, rdVal);
        chk(rdVal, 16'h0040 | cw);
      end
    end
    $display("test routing done");
    wr(`CSTS_OFF_CTRL2, 16'h00CB);
    rd(`CSTS_OFF_CTRL2, rdVal);
    chk(rdVal, 16'h00CB);
    chk(16'({trigMode, trigStatus}), 16'h0003);
    wr(`CSTS_OFF_CTRL2, 16'h000B);
    rd(`CSTS_OFF_CTRL2, rdVal);
    chk(rdVal, 16'h000B);
    wr(8'h10, 16'hFFFF);
    rd(8'h10, rdVal);
    chk(rdVal, 16'h0000);
    rd(`CSTS_OFF_CTRL2, rdVal);
    chk(rdVal, 16'h000B);
    $display("test status done");
    for (int k = 0; k < 4; k++) begin
      wr(`CSTS_OFF_CTRL2, (k >= 2) ? 16'h010B : 16'h000B);
      partnerCascadeEn <= (k % 2 == 1);
      @(posedge clk);
      #1;
      chk(16'(cascadeActive), 16'(k == 3));
      chk(16'(cascadeEnable), 16'(k >= 2));
      rd(`CSTS_OFF_STATE, rdVal);
      chk(rdVal, {14'h0000, (k % 2 == 1), (k == 3)});
    end
    $display("test cascade done");
    wr(`CSTS_OFF_CTRL2, 16'h000B);
    wr(`CSTS_OFF_IRQ_STAT, 16'h0007);
    wr(`CSTS_OFF_IRQ_MASK, 16'h0001);
    rd(`CSTS_OFF_IRQ_MASK, rdVal);
    chk(rdVal, 16'h0001);
    fire(22'h1 << 17, n);
    chk(16'(irq), 16'h0001);
    rd(`CSTS_OFF_IRQ_STAT, rdVal);
    chk(rdVal, 16'h0003);
    wr(`CSTS_OFF_IRQ_STAT, 16'h0003);
    #1;
    chk(16'(irq), 16'h0000);
    wr(`CSTS_OFF_IRQ_MASK, 16'h0000);
    fire(22'h1 << 17, n);
    chk(16'(irq), 16'h0000);
    rd(`CSTS_OFF_IRQ_STAT, rdVal);
    chk(rdVal, 16'h0001);
    wr(`CSTS_OFF_IRQ_STAT, 16'h0007);
    wr(`CSTS_OFF_CTRL2, 16'h0005);
    rd(`CSTS_OFF_IRQ_STAT, rdVal);
    chk(rdVal, 16'h0004);
    rd(`CSTS_OFF_STATE, rdVal);
    chk(rdVal, 16'h0006);
    $display("test interrupt done");
    give_verdict();
  end
endmodule // tb_capture_sync_trigger_select
`default_nettype wire
